// [src/sub_sleep_pkg.sv]
/*
  Constants and types for the subtract and power-down execution block:
  register offsets, status field positions, reset values, opcodes, phases.
  Assumes an APB slave with 32-bit data and byte addresses.
*/
package sub_sleep_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFF_INSTR  = 8'h00;
  localparam logic [7:0] OFF_WORKING_REGISTER   = 8'h04;
  localparam logic [7:0] OFF_FILE   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_STATE  = 8'h10;

  // Status field positions
  localparam int unsigned ST_CARRY   = 0;
  localparam int unsigned ST_NIBBLE  = 1;
  localparam int unsigned ST_ZERO    = 2;
  localparam int unsigned ST_WRAP    = 3;
  localparam int unsigned ST_PDOWN   = 4;
  localparam int unsigned ST_TIMEOUT = 5;

  // State register field positions
  localparam int unsigned SB_BUSY  = 0;
  localparam int unsigned SB_SLEEP = 1;

  // Reset values
  localparam logic [7:0]  WORKING_REGISTER_RST    = 8'h00;
  localparam logic [7:0]  FILE_RST    = 8'h00;
  localparam logic [15:0] INSTR_RST   = 16'h0000;
  localparam logic        TIMEOUT_RST = 1'b1;
  localparam logic        PDOWN_RST   = 1'b1;

  // Opcodes
  localparam logic [7:0]  OPC_SUBTRACT_WORKING_REGISTER_FROM_LITERAL_HI  = 8'hB2;
  localparam logic [6:0]  OPC_SUBTRACT_WORKING_REGISTER_FROM_FILE_HI  = 7'h02;
  localparam logic [6:0]  OPC_SUBTRACT_WORKING_REGISTER_FROM_FILE_BORROW_HI = 7'h01;
  localparam logic [15:0] OPC_SLEEP     = 16'h0003;

  // Instruction phases, Gray coded along idle-q1-q2-q3-q4
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_Q1   = 3'b001,
    PH_Q2   = 3'b011,
    PH_Q3   = 3'b010,
    PH_Q4   = 3'b110
  } phase_type;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL,
    OP_SUBTRACT_WORKING_REGISTER_FROM_FILE,
    OP_SUBTRACT_WORKING_REGISTER_FROM_FILE_BORROW,
    OP_SLEEP
  } op_type;

  typedef struct packed {
    logic timeout;
    logic pdown;
    logic wrap;
    logic zero;
    logic nibble;
    logic carry;
  } flags_type;

  typedef struct packed {
    logic [7:0] res;
    flags_type  flags;
  } alu_out_type;

endpackage

// [src/sub_sleep_exec.sv]
/*
  Subtract and power-down execution block with an APB register slave.
  Software writes an instruction word; it runs through four phases
  (decode, read, process, write) and commits on the last.
  Assumes a zero-wait APB master and synchronous wake inputs.
*/
// Local design decisions: register access over APB and the address map.
// Functional notes
// - Literal subtract: literal minus working register into working register.
// - Literal subtract decoded by upper byte 1011 0010, literal in low byte.
// - Subtracts update only wrap, borrow-inverse, nibble-borrow, zero flags.
// - Borrow clears the borrow-inverse flag; no borrow sets it.
// - Negative results are stored as 8-bit two's complement.
// - Power-down sets timeout flag; watchdog wake-up clears it.
// - Power-down clears power-down flag, watchdog; final phase sleeps, osc off.
// - Power-down decoded by fixed word 0000 0000 0000 0011.
`timescale 1ns/1ps
module sub_sleep_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        wake_watchdog,
  input  wire logic        wake_event,
  output logic             sleep_active,
  output logic             osc_stopped,
  output logic             watchdog_clear
);

  sub_sleep_pkg::phase_type   phase_q;
  sub_sleep_pkg::phase_type   phase_d;
  sub_sleep_pkg::op_type      op_q;
  sub_sleep_pkg::flags_type   flags_q;
  sub_sleep_pkg::alu_out_type alu;
  logic [15:0] instr_q;
  logic [7:0]  working_register_q;
  logic [7:0]  file_q;
  logic        sleep_q;
  logic        wdt_clr_q;
  logic        wr_en;
  logic        rd_en;
  logic        hit;
  logic        start;
  logic        commit;
  logic        to_file;

  // Decode used only by the launch path; read-back returns the raw instruction word
  function automatic sub_sleep_pkg::op_type decode(input logic [15:0] w);
    if (w[15:8] == sub_sleep_pkg::OPC_SUBTRACT_WORKING_REGISTER_FROM_LITERAL_HI) begin
      decode = sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL;
    end else if (w[15:9] == sub_sleep_pkg::OPC_SUBTRACT_WORKING_REGISTER_FROM_FILE_HI) begin
      decode = sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_FILE;
    end else if (w[15:9] == sub_sleep_pkg::OPC_SUBTRACT_WORKING_REGISTER_FROM_FILE_BORROW_HI) begin
      decode = sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_FILE_BORROW;
    end else if (w == sub_sleep_pkg::OPC_SLEEP) begin
      decode = sub_sleep_pkg::OP_SLEEP;
    end else begin
      decode = sub_sleep_pkg::OP_NONE;
    end
  endfunction

  // APB: zero wait states, every access completes in its access phase
  assign pready  = 1'b1;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;
  assign hit     = (paddr == sub_sleep_pkg::OFF_INSTR)
                || (paddr == sub_sleep_pkg::OFF_WORKING_REGISTER)
                || (paddr == sub_sleep_pkg::OFF_FILE)
                || (paddr == sub_sleep_pkg::OFF_STATUS)
                || (paddr == sub_sleep_pkg::OFF_STATE);
  assign pslverr = psel && penable && !hit;

  // Launch only when idle and awake; other writes to the word are dropped
  assign start  = wr_en && (paddr == sub_sleep_pkg::OFF_INSTR)
               && (phase_q == sub_sleep_pkg::PH_IDLE) && !sleep_q;
  assign commit = (phase_q == sub_sleep_pkg::PH_Q4);
  assign to_file = instr_q[8] && (op_q != sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL);

  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      sub_sleep_pkg::PH_IDLE: if (start) phase_d = sub_sleep_pkg::PH_Q1;
      sub_sleep_pkg::PH_Q1:   phase_d = sub_sleep_pkg::PH_Q2;
      sub_sleep_pkg::PH_Q2:   phase_d = sub_sleep_pkg::PH_Q3;
      sub_sleep_pkg::PH_Q3:   phase_d = sub_sleep_pkg::PH_Q4;
      default:                phase_d = sub_sleep_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= sub_sleep_pkg::PH_IDLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= sub_sleep_pkg::INSTR_RST;
      op_q    <= sub_sleep_pkg::OP_NONE;
    end else if (start) begin
      instr_q <= pwdata[15:0];
      op_q    <= decode(pwdata[15:0]);
    end
  end

  // Subtract by adding the complement; carry out is borrow-inverse
  always_comb begin
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [8:0] sum;
    logic [4:0] low;
    a   = 8'h00;
    b   = working_register_q;
    cin = 1'b1;
    sum = 9'h000;
    low = 5'h00;
    if (op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL) begin
      a = instr_q[7:0];
    end else begin
      a = file_q;
    end
    if (op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_FILE_BORROW) begin
      cin = flags_q.carry;
    end
    sum = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    alu = '0;
    alu.res          = sum[7:0];
    alu.flags        = flags_q;
    alu.flags.carry  = sum[8];
    alu.flags.nibble = low[4];
    alu.flags.zero   = (sum[7:0] == 8'h00);
    alu.flags.wrap   = (a[7] != b[7]) && (sum[7] != a[7]);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      working_register_q <= sub_sleep_pkg::WORKING_REGISTER_RST;
    end else if (commit && op_q != sub_sleep_pkg::OP_NONE
                 && op_q != sub_sleep_pkg::OP_SLEEP && !to_file) begin
      working_register_q <= alu.res;
    end else if (wr_en && paddr == sub_sleep_pkg::OFF_WORKING_REGISTER) begin
      working_register_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      file_q <= sub_sleep_pkg::FILE_RST;
    end else if (commit && to_file && (op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_FILE
                 || op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_FILE_BORROW)) begin
      file_q <= alu.res;
    end else if (wr_en && paddr == sub_sleep_pkg::OFF_FILE) begin
      file_q <= pwdata[7:0];
    end
  end

  // Execution outranks a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q         <= '0;
      flags_q.timeout <= sub_sleep_pkg::TIMEOUT_RST;
      flags_q.pdown   <= sub_sleep_pkg::PDOWN_RST;
    end else if (commit && op_q == sub_sleep_pkg::OP_SLEEP) begin
      flags_q.timeout <= 1'b1;
      flags_q.pdown   <= 1'b0;
    end else if (commit && op_q != sub_sleep_pkg::OP_NONE) begin
      flags_q <= alu.flags;
    end else if (sleep_q && wake_watchdog) begin
      flags_q.timeout <= 1'b0;
    end else if (wr_en && paddr == sub_sleep_pkg::OFF_STATUS) begin
      flags_q.carry  <= pwdata[sub_sleep_pkg::ST_CARRY];
      flags_q.nibble <= pwdata[sub_sleep_pkg::ST_NIBBLE];
      flags_q.zero   <= pwdata[sub_sleep_pkg::ST_ZERO];
      flags_q.wrap   <= pwdata[sub_sleep_pkg::ST_WRAP];
    end
  end

  // Sleep begins at the final phase; any wake source ends it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_q <= 1'b0;
    end else if (commit && op_q == sub_sleep_pkg::OP_SLEEP) begin
      sleep_q <= 1'b1;
    end else if (wake_watchdog || wake_event) begin
      sleep_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clr_q <= 1'b0;
    end else begin
      wdt_clr_q <= commit && (op_q == sub_sleep_pkg::OP_SLEEP);
    end
  end

  assign sleep_active   = sleep_q;
  assign osc_stopped    = sleep_q;
  assign watchdog_clear = wdt_clr_q;

  // Read data captured in the setup phase, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      if (paddr == sub_sleep_pkg::OFF_INSTR) begin
        prdata <= {16'h0000, instr_q};
      end else if (paddr == sub_sleep_pkg::OFF_WORKING_REGISTER) begin
        prdata <= {24'h00_0000, working_register_q};
      end else if (paddr == sub_sleep_pkg::OFF_FILE) begin
        prdata <= {24'h00_0000, file_q};
      end else if (paddr == sub_sleep_pkg::OFF_STATUS) begin
        prdata <= {26'h000_0000, flags_q};
      end else if (paddr == sub_sleep_pkg::OFF_STATE) begin
        prdata <= {30'h0000_0000, sleep_q,
                   phase_q != sub_sleep_pkg::PH_IDLE};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  sequence s_sub_commit;
    commit && (op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL
      || op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_FILE
      || op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_FILE_BORROW);
  endsequence

  sequence s_sleep_commit;
    commit && op_q == sub_sleep_pkg::OP_SLEEP;
  endsequence

  a_literal_sub_result: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL
    |=> working_register_q == 8'(instr_q[7:0] - $past(working_register_q)))
    else $error("literal subtract result wrong");

  a_decode_literal: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && pwdata[15:8] == sub_sleep_pkg::OPC_SUBTRACT_WORKING_REGISTER_FROM_LITERAL_HI
    |=> op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL ##3 commit)
    else $error("literal subtract not decoded");

  a_flags_only_four: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_sub_commit |=> $stable({flags_q.timeout, flags_q.pdown}))
    else $error("subtract touched power flags");

  a_borrow_inverse: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL
    |=> flags_q.carry == (instr_q[7:0] >= $past(working_register_q)))
    else $error("borrow-inverse flag wrong");

  a_nibble_borrow: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL
    |=> flags_q.nibble == (instr_q[3:0] >= $past(working_register_q[3:0])))
    else $error("nibble borrow flag wrong");

  // Checked against the written destination, not the adder output
  a_wrap_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_LITERAL
    |=> flags_q.wrap == (instr_q[7] != $past(working_register_q[7])
      && working_register_q[7] != instr_q[7]))
    else $error("signed wrap flag wrong");

  a_zero_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_sub_commit
    |=> flags_q.zero == ((to_file ? file_q : working_register_q) == 8'h00))
    else $error("zero flag wrong");

  a_sleep_flags: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_sleep_commit |=> flags_q.timeout && !flags_q.pdown
      && sleep_active && osc_stopped && watchdog_clear)
    else $error("power-down entry wrong");

  a_watchdog_wake: assert property (
    @(posedge pclk) disable iff (!presetn)
    sleep_q && wake_watchdog |=> !flags_q.timeout && !sleep_active)
    else $error("watchdog wake did not clear timeout");

  a_wdt_pulse: assert property (
    @(posedge pclk) disable iff (!presetn)
    watchdog_clear |=> !watchdog_clear)
    else $error("watchdog clear longer than one cycle");

  a_sleep_phases: assert property (
    @(posedge pclk) disable iff (!presetn)
    start && pwdata[15:0] == sub_sleep_pkg::OPC_SLEEP
    |=> !sleep_active [*4] ##1 sleep_active)
    else $error("sleep not entered at final phase");

  a_file_dest: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit && op_q == sub_sleep_pkg::OP_SUBTRACT_WORKING_REGISTER_FROM_FILE && instr_q[8]
    |=> file_q == 8'($past(file_q) - $past(working_register_q)) && $stable(working_register_q))
    else $error("file subtract destination wrong");

endmodule

// [dv/testbench.sv]
/*
  Self-checking bench for sub_sleep_exec: APB master tasks and an integer
  model of the working register, file register and status flags.
  Assumes the package register offsets and the hand-over timing.
*/
`timescale 1ns/1ps
`define CHK(a,b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("BAD %0t got %0h exp %0h", $time, a, b); end end
module testbench;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        wake_watchdog;
  logic        wake_event;
  logic        sleep_active;
  logic        osc_stopped;
  logic        watchdog_clear;
  logic [31:0] q;
  logic        err_q;
  logic [15:0] ins;
  int          n_errors, cmp_count, wdc_n;
  int          w, f, c, dc, z, ov, pd, to, i, k, d, r, kind;

  sub_sleep_exec i_dut (
    .pclk           (pclk),
    .presetn        (presetn),
    .psel           (psel),
    .penable        (penable),
    .pwrite         (pwrite),
    .paddr          (paddr),
    .pwdata         (pwdata),
    .prdata         (prdata),
    .pready         (pready),
    .pslverr        (pslverr),
    .wake_watchdog  (wake_watchdog),
    .wake_event     (wake_event),
    .sleep_active   (sleep_active),
    .osc_stopped    (osc_stopped),
    .watchdog_clear (watchdog_clear)
  );

  always #20 pclk = ~pclk;

  task results;
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
    int t;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (t == 20) begin n_errors++; results(); end
    q = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task run(input logic [15:0] op);
    int t;
    apb(1'b1, sub_sleep_pkg::OFF_INSTR, {16'h0000, op});
    for (t = 0; t < 20; t++) begin
      apb(1'b0, sub_sleep_pkg::OFF_STATE, 32'h0);
      if (q[sub_sleep_pkg::SB_BUSY] === 1'b0) break;
    end
    if (t == 20) begin n_errors++; results(); end
  endtask

  task chk_all;
    apb(1'b0, sub_sleep_pkg::OFF_WORKING_REGISTER, 32'h0);
    `CHK(q, 32'(w))
    apb(1'b0, sub_sleep_pkg::OFF_FILE, 32'h0);
    `CHK(q, 32'(f))
    apb(1'b0, sub_sleep_pkg::OFF_STATUS, 32'h0);
    `CHK(q, 32'(to*32 + pd*16 + ov*8 + z*4 + dc*2 + c))
    `CHK(err_q, 1'b0)
  endtask

  // Level held until the block leaves sleep, then dropped
  task wake(input logic wd);
    int t;
    @(posedge pclk);
    if (wd) wake_watchdog <= 1'b1;
    else wake_event <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge pclk);
      if (sleep_active === 1'b0) break;
    end
    if (t == 20) begin n_errors++; results(); end
    wake_watchdog <= 1'b0;
    wake_event    <= 1'b0;
  endtask

  // a - b - borrow as a + ~b + carry_in
  function automatic int sub(int kd, int a, int b);
    int cin, s;
    cin = (kd == 2) ? c : 1;
    s = a + (255 - b) + cin;
    dc = ((a % 16) + (15 - b % 16) + cin) > 15;
    c = s > 255;
    s = s % 256;
    z = (s == 0);
    ov = ((a ^ b) & (a ^ s) & 128) != 0;
    return s;
  endfunction

  always @(negedge pclk) begin
    if (presetn && watchdog_clear === 1'b1) begin
      wdc_n++;
      `CHK(sleep_active, 1'b1)
    end
  end

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; wake_watchdog = 0; wake_event = 0;
    w = 0; f = 0; c = 0; dc = 0; z = 0; ov = 0; pd = 1; to = 1;
    void'($urandom(81));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk_all();
    apb(1'b1, 8'h14, 32'hFF);
    `CHK(err_q, 1'b1)
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err_q, q}, {1'b1, 32'h0})
    for (i = 0; i < 12; i++) begin
      k = (i == 0) ? 2 : $urandom % 256;
      d = (i == 0) ? 3 : (i == 1) ? k : $urandom % 256;
      apb(1'b1, sub_sleep_pkg::OFF_WORKING_REGISTER, 32'(d));
      run({8'hB2, 8'(k)});
      w = sub(0, k, d);
      chk_all();
    end
    for (i = 0; i < 16; i++) begin
      kind = (i % 4 < 2) ? 1 : 2;
      w = $urandom % 256;
      f = (i == 3) ? w : $urandom % 256;
      k = $urandom % 16;
      c = k % 2; dc = (k / 2) % 2; z = (k / 4) % 2; ov = k / 8;
      apb(1'b1, sub_sleep_pkg::OFF_WORKING_REGISTER, 32'(w));
      apb(1'b1, sub_sleep_pkg::OFF_FILE, 32'(f));
      apb(1'b1, sub_sleep_pkg::OFF_STATUS, 32'(k));
      ins = {(kind == 1) ? 7'h02 : 7'h01, 1'(i % 2), 8'h20};
      run(ins);
      r = sub(kind, f, w);
      if (i % 2 == 1) f = r;
      else w = r;
      chk_all();
    end
    // Unknown opcode must leave everything alone
    run(16'hB302);
    chk_all();
    run(16'h0003);
    pd = 0;
    to = 1;
    chk_all();
    `CHK({sleep_active, osc_stopped}, 2'b11)
    // Instruction written while asleep is dropped
    apb(1'b1, sub_sleep_pkg::OFF_INSTR, 32'h0000B200);
    apb(1'b0, sub_sleep_pkg::OFF_STATE, 32'h0);
    `CHK(q, 32'h2)
    wake(1'b0);
    chk_all();
    run(16'h0003);
    wake(1'b1);
    to = 0;
    chk_all();
    apb(1'b0, sub_sleep_pkg::OFF_STATE, 32'h0);
    `CHK(q, 32'h0)
    `CHK(wdc_n, 2)
    results();
  end
endmodule
